//--- inc/pcs_pkg.sv
// Purpose: Shared constants for the program counter and stack block
// Assumes: One instruction clock, synchronous core strobes
// Notes:   Register offsets and field positions live here only
package pcs_pkg;
  // ==========================================================
  // Address widths and vectors
  localparam int PC_W = 15;                          // Program counter width
  localparam int WORD_W = 14;                        // Program word width
  localparam int PTR_W = 16;                         // Indirect pointer width
  localparam int DADDR_W = 12;                       // Data address width
  localparam logic [14:0] RESET_VEC = 15'h0000;      // Start of program memory
  localparam logic [14:0] INT_VEC = 15'h0004;        // Interrupt entry point
  localparam logic [14:0] HEF_WORDS = 15'h0080;      // Top region of 128 words
  localparam logic [13:0] HEF_LANES = 14'h00ff;      // Only low byte endures
  // ==========================================================
  // Pointer decode
  localparam int PTR_PROG_BIT = 15;                  // Bit 7 of pointer high byte
  localparam logic [15:0] LIN_BASE = 16'h2000;       // Linear GPR window start
  localparam logic [15:0] LIN_SIZE = 16'h0a00;       // Room for 32 banks of 80
  localparam logic [6:0] GPR_SPAN = 7'h50;           // 80 bytes per bank
  localparam logic [6:0] GPR_OFS = 7'h20;            // GPR start inside a bank
  // ==========================================================
  // Register map, 8-bit data
  localparam logic [3:0] REG_CTRL = 4'h0;            // Control
  localparam logic [3:0] REG_PWR = 4'h1;             // Power control / status
  localparam logic [3:0] REG_MASK = 4'h2;            // Interrupt mask
  localparam logic [3:0] REG_PCL = 4'h3;             // Program counter low
  localparam logic [3:0] REG_PCH = 4'h4;             // Program counter high
  localparam logic [3:0] REG_DEPTH = 4'h5;           // Stack fill level
  localparam int CTRL_STKRST = 0;                    // Stack error reset enable
  localparam int FLG_OVF = 0;                        // Stack overflow flag
  localparam int FLG_UNF = 1;                        // Stack underflow flag
  localparam int FLG_W = 2;                          // Number of event flags
  // ==========================================================
  // Linear GPR view to banked address
  function automatic logic [11:0] pcs_lin_map(input logic [15:0] ofs);
    logic [15:0] bank;
    logic [15:0] rem;
    bank = ofs / 16'(GPR_SPAN);
    rem = ofs - bank * 16'(GPR_SPAN);
    return {bank[4:0], rem[6:0] + GPR_OFS};
  endfunction
  // Indirect pointer aims at program memory
  function automatic logic pcs_is_prog(input logic [15:0] ptr);
    return ptr[PTR_PROG_BIT];
  endfunction
endpackage

//--- design/pcs_stack.sv
// Purpose: Return address stack with overflow and underflow detection
// Assumes: Never push and pop in one cycle
// Notes:   Full push and empty pop leave the stack untouched
module pcs_stack
#(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Stack operations
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_data,
  // Results
  output logic [WIDTH-1:0] top_data,
  output logic [$clog2(DEPTH):0] depth,
  output logic ovf_evt,
  output logic unf_evt
);
  import pcs_pkg::*;
  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("pcs_stack: DEPTH must be a power of two");
  end
  // ==========================================================
  // Storage
  logic [WIDTH-1:0] mem_ff [DEPTH];                  // Entries kept off the data map
  logic [$clog2(DEPTH):0] cnt_ff;                    // Entries in use
  logic full;
  logic empty;
  assign full = (cnt_ff == ($clog2(DEPTH)+1)'(DEPTH));
  assign empty = (cnt_ff == '0);
  // Events are combinational so the flag sets in the same edge
  assign ovf_evt = push && full;
  assign unf_evt = pop && empty;
  assign depth = cnt_ff;
  // Top entry; reads zero when empty
  assign top_data = empty ? '0 : mem_ff[cnt_ff[$clog2(DEPTH)-1:0] - 1'b1];
  // ==========================================================
  // Fill level, empty after any reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cnt_ff <= '0;
    else if (push && !full)
      cnt_ff <= cnt_ff + 1'b1;
    else if (pop && !empty)
      cnt_ff <= cnt_ff - 1'b1;
  end
  // Entry write; memory needs no reset
  always_ff @(posedge clk_sys)
  begin
    if (push && !full)
      mem_ff[cnt_ff[$clog2(DEPTH)-1:0]] <= push_data;
  end
endmodule // pcs_stack

//--- design/pcs_indirect.sv
// Purpose: Two 16-bit indirect pointers and their address decode
// Assumes: Pointer bytes written one at a time by the core
// Notes:   Decode is combinational from the pointer flops
module pcs_indirect
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pointer byte writes
  input wire logic ptr_wr,
  input wire logic ptr_wsel,
  input wire logic ptr_whigh,
  input wire logic [7:0] ptr_wdata,
  // Access selection
  input wire logic ptr_sel,
  // Decoded view of selected pointer
  output logic [pcs_pkg::PTR_W-1:0] ptr_value,
  output logic ptr_is_prog,
  output logic [pcs_pkg::PC_W-1:0] ptr_prog_addr,
  output logic [pcs_pkg::DADDR_W-1:0] ptr_data_addr
);
  import pcs_pkg::*;
  // ==========================================================
  // Pointer storage, one generate slice per pointer
  logic [PTR_W-1:0] ptr_ff [2];
  for (genvar i = 0; i < 2; i++)
  begin : g_ptr
    always_ff @(posedge clk_sys or posedge rst)
    begin
      if (rst)
        ptr_ff[i] <= '0;
      else if (ptr_wr && ptr_wsel == 1'(i))
      begin
        // High or low byte of this pointer
        if (ptr_whigh)
          ptr_ff[i][15:8] <= ptr_wdata;
        else
          ptr_ff[i][7:0] <= ptr_wdata;
      end
    end
  end
  // ==========================================================
  // Decode: program, linear GPR, or traditional banked address
  logic [PTR_W-1:0] lin_ofs;
  assign ptr_value = ptr_ff[ptr_sel];
  assign lin_ofs = ptr_value - LIN_BASE;
  assign ptr_is_prog = pcs_is_prog(ptr_value);
  assign ptr_prog_addr = ptr_value[PC_W-1:0];
  always_comb
  begin
    if (ptr_value >= LIN_BASE && lin_ofs < LIN_SIZE)
      ptr_data_addr = pcs_lin_map(lin_ofs);
    else
      ptr_data_addr = ptr_value[DADDR_W-1:0];
  end
endmodule // pcs_indirect

//--- design/pcs_core.sv
// Purpose: Program counter, return stack, context shadows and indirect access
// Assumes: Core strobes are one-cycle and held off while stall is high
// Notes:   Registers on a plain 8-bit port, read data one cycle later
// Notes on behaviour
// - Fifteen-bit counter over 32K fourteen-bit words
// - Out-of-range addresses wrap into implemented memory
// - Any reset loads counter with 0000h
// - Taken interrupt loads counter with 0004h
// - Sixteen by fifteen-bit return stack, off data map
// - Full push sets overflow, empty pop underflow
// - Enabled stack errors also request device reset
// - Shadows saved on interrupt, restored on return
// - Two sixteen-bit pointers reach all file registers
// - Program-memory indirect reads cost one extra cycle
// - Linear GPR view beyond 80-byte banks
// - Top 128 words form high-endurance region
// - Only low byte of those words endures
// - Pointer bit 15 selects program; low byte returned
// - Indirect writes to program memory are dropped
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
module pcs_core
#(
  parameter int PROG_WORDS = 8192,
  parameter int STACK_DEPTH = 16
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Program flow strobes from the sequencer
  input wire logic pc_inc,
  input wire logic pc_jump,
  input wire logic pc_call,
  input wire logic pc_ret,
  input wire logic pc_retint,
  input wire logic int_take,
  input wire logic [pcs_pkg::PC_W-1:0] pc_target,
  output logic stall,
  // Program flash array port
  output logic [pcs_pkg::PC_W-1:0] pfm_addr,
  input wire logic [pcs_pkg::WORD_W-1:0] pfm_rdata,
  output logic pfm_hef_hit,
  output logic [pcs_pkg::WORD_W-1:0] pfm_hef_lanes,
  // Context to shadow
  input wire logic [7:0] ctx_w,
  input wire logic [7:0] ctx_status,
  input wire logic [7:0] ctx_bsr,
  input wire logic [7:0] ctx_pclath,
  output logic [7:0] shd_w,
  output logic [7:0] shd_status,
  output logic [7:0] shd_bsr,
  output logic [7:0] shd_pclath,
  output logic ctx_restore,
  // Indirect pointer writes and indirect data port
  input wire logic ptr_wr,
  input wire logic ptr_wsel,
  input wire logic ptr_whigh,
  input wire logic [7:0] ptr_wdata,
  input wire logic ind_rd,
  input wire logic ind_wr,
  input wire logic ind_sel,
  input wire logic [7:0] ind_wdata,
  output logic ind_valid,
  output logic [7:0] ind_rdata,
  // Data memory side of indirect access
  output logic [pcs_pkg::DADDR_W-1:0] dmem_addr,
  output logic dmem_rd,
  output logic dmem_wr,
  output logic [7:0] dmem_wdata,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // System outputs
  output logic irq,
  output logic stack_reset_req
);
  import pcs_pkg::*;
  initial
  begin
    if (PROG_WORDS != 8192 && PROG_WORDS != 16384)
      $error("pcs_core: PROG_WORDS must be 8192 or 16384");
    if (STACK_DEPTH != 16)
      $error("pcs_core: STACK_DEPTH must be 16");
  end
  // ==========================================================
  // Declarations
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,                                  // Normal instruction flow
    ST_PFETCH = 2'b10                                // Extra cycle for program read
  } pcs_state_type;
  localparam logic [PC_W-1:0] ADDR_MASK = PC_W'(PROG_WORDS - 1);
  localparam logic [PC_W-1:0] HEF_BASE = PC_W'(PROG_WORDS) - HEF_WORDS;
  pcs_state_type state_ff;                           // Access sequencer
  pcs_state_type nxt_state;
  logic [PC_W-1:0] pc_ff;                            // Program counter
  logic [PC_W-1:0] nxt_pc;
  logic [PC_W-1:0] top_data;                         // Popped return address
  logic [$clog2(STACK_DEPTH):0] depth;
  logic ovf_evt;
  logic unf_evt;
  logic do_push;
  logic do_pop;
  logic [PC_W-1:0] push_data;
  logic [PTR_W-1:0] ptr_value;
  logic ptr_is_prog;
  logic [PC_W-1:0] ptr_prog_addr;
  logic [DADDR_W-1:0] ptr_data_addr;
  logic [PC_W-1:0] fetch_addr_ff;                    // Pointer address held for fetch
  logic [7:0] ind_rdata_ff;
  logic ind_valid_ff;
  logic [DADDR_W-1:0] dmem_addr_ff;
  logic dmem_rd_ff;
  logic dmem_wr_ff;
  logic [7:0] dmem_wdata_ff;
  logic [7:0] shd_w_ff;
  logic [7:0] shd_status_ff;
  logic [7:0] shd_bsr_ff;
  logic [7:0] shd_pclath_ff;
  logic ctx_restore_ff;
  logic ctrl_stkrst_ff;                              // Stack error reset enable
  logic [FLG_W-1:0] flag_ff;                         // Sticky stack error flags
  logic [FLG_W-1:0] mask_ff;                         // Interrupt enables
  logic [FLG_W-1:0] evt;
  logic [7:0] reg_rdata_ff;
  logic stack_reset_req_ff;
  logic [PC_W-1:0] pc_wrapped;
  // ==========================================================
  // Return stack and pointers
  pcs_stack #(.DEPTH(STACK_DEPTH), .WIDTH(PC_W)) u_stack (
    .clk_sys(clk_sys),
    .rst(rst),
    .push(do_push),
    .pop(do_pop),
    .push_data(push_data),
    .top_data(top_data),
    .depth(depth),
    .ovf_evt(ovf_evt),
    .unf_evt(unf_evt)
  );
  pcs_indirect u_ind (
    .clk_sys(clk_sys),
    .rst(rst),
    .ptr_wr(ptr_wr),
    .ptr_wsel(ptr_wsel),
    .ptr_whigh(ptr_whigh),
    .ptr_wdata(ptr_wdata),
    .ptr_sel(ind_sel),
    .ptr_value(ptr_value),
    .ptr_is_prog(ptr_is_prog),
    .ptr_prog_addr(ptr_prog_addr),
    .ptr_data_addr(ptr_data_addr)
  );
  // ==========================================================
  // Stack operations; an interrupt saves the current counter
  assign do_push = int_take || (pc_call && !stall);
  assign do_pop = !int_take && (pc_ret || pc_retint) && !stall;
  assign push_data = int_take ? pc_ff : pc_ff + 1'b1;
  // ==========================================================
  // Program counter next value; interrupt has top priority
  always_comb
  begin
    nxt_pc = pc_ff;
    if (int_take)
      nxt_pc = INT_VEC;
    else if (stall)
      nxt_pc = pc_ff;                                // Held in the cycle the program read is requested
    else if (pc_ret || pc_retint)
      nxt_pc = top_data;
    else if (pc_call || pc_jump)
      nxt_pc = pc_target;
    else if (pc_inc)
      nxt_pc = pc_ff + 1'b1;
  end
  // Counter register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pc_ff <= RESET_VEC;
    else
      pc_ff <= nxt_pc;
  end
  // ==========================================================
  // Flash address: fold into implemented size, fetch uses pointer
  assign pc_wrapped = pc_ff & ADDR_MASK;
  assign pfm_addr = (state_ff == ST_PFETCH) ? fetch_addr_ff : pc_wrapped;
  // High-endurance region covers the top words, low byte only
  assign pfm_hef_hit = (pfm_addr >= HEF_BASE);
  assign pfm_hef_lanes = pfm_hef_hit ? HEF_LANES : '0;
  // ==========================================================
  // Indirect sequencer: program reads take one extra cycle
  assign stall = (state_ff == ST_RUN) && ind_rd && ptr_is_prog;
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN:
        if (stall)
          nxt_state = ST_PFETCH;
      ST_PFETCH:
        nxt_state = ST_RUN;
      default:
        nxt_state = ST_RUN;                          // Recover from bad code
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_ff <= ST_RUN;
    else
      state_ff <= nxt_state;
  end
  // Fetch address latched when the program read is seen
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      fetch_addr_ff <= '0;
    else if (stall)
      fetch_addr_ff <= ptr_prog_addr & ADDR_MASK;
  end
  // Program read returns the low eight bits of the word
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ind_rdata_ff <= '0;
      ind_valid_ff <= 1'b0;
    end
    else
    begin
      ind_valid_ff <= (state_ff == ST_PFETCH);
      if (state_ff == ST_PFETCH)
        ind_rdata_ff <= pfm_rdata[7:0];
    end
  end
  // Data side strobes; a write aimed at program memory goes nowhere
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dmem_addr_ff <= '0;
      dmem_rd_ff <= 1'b0;
      dmem_wr_ff <= 1'b0;
      dmem_wdata_ff <= '0;
    end
    else
    begin
      dmem_rd_ff <= ind_rd && !ptr_is_prog && (state_ff == ST_RUN);
      dmem_wr_ff <= ind_wr && !ptr_is_prog;
      if ((ind_rd || ind_wr) && !ptr_is_prog)
      begin
        dmem_addr_ff <= ptr_data_addr;
        dmem_wdata_ff <= ind_wdata;
      end
    end
  end
  // ==========================================================
  // Context shadows: save on entry, pulse restore on return
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      shd_w_ff <= '0;
      shd_status_ff <= '0;
      shd_bsr_ff <= '0;
      shd_pclath_ff <= '0;
      ctx_restore_ff <= 1'b0;
    end
    else
    begin
      ctx_restore_ff <= pc_retint && !int_take && !stall;
      if (int_take)
      begin
        shd_w_ff <= ctx_w;
        shd_status_ff <= ctx_status;
        shd_bsr_ff <= ctx_bsr;
        shd_pclath_ff <= ctx_pclath;
      end
    end
  end
  // ==========================================================
  // Control, flags and mask; a new event beats a clear
  assign evt[FLG_OVF] = ovf_evt;
  assign evt[FLG_UNF] = unf_evt;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      flag_ff <= '0;
    else if (reg_wr && reg_addr == REG_PWR)
      flag_ff <= (flag_ff & ~reg_wdata[FLG_W-1:0]) | evt;
    else
      flag_ff <= flag_ff | evt;
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_stkrst_ff <= 1'b0;
      mask_ff <= '0;
    end
    else if (reg_wr)
    begin
      // Only writable registers respond
      if (reg_addr == REG_CTRL)
        ctrl_stkrst_ff <= reg_wdata[CTRL_STKRST];
      if (reg_addr == REG_MASK)
        mask_ff <= reg_wdata[FLG_W-1:0];
    end
  end
  // Reset request is a one-cycle pulse for the reset controller
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      stack_reset_req_ff <= 1'b0;
    else
      stack_reset_req_ff <= ctrl_stkrst_ff && (|evt);
  end
  // ==========================================================
  // Register read, answered the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      reg_rdata_ff <= '0;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        REG_CTRL: reg_rdata_ff <= 8'(ctrl_stkrst_ff);
        REG_PWR: reg_rdata_ff <= 8'(flag_ff);
        REG_MASK: reg_rdata_ff <= 8'(mask_ff);
        REG_PCL: reg_rdata_ff <= pc_ff[7:0];
        REG_PCH: reg_rdata_ff <= 8'(pc_ff[PC_W-1:8]);
        REG_DEPTH: reg_rdata_ff <= 8'(depth);
        default: reg_rdata_ff <= '0;                 // Unmapped reads zero
      endcase
    end
    else
      reg_rdata_ff <= '0;
  end
  // ==========================================================
  // Outputs
  assign irq = |(flag_ff & mask_ff);
  assign reg_rdata = reg_rdata_ff;
  assign stack_reset_req = stack_reset_req_ff;
  assign ind_rdata = ind_rdata_ff;
  assign ind_valid = ind_valid_ff;
  assign dmem_addr = dmem_addr_ff;
  assign dmem_rd = dmem_rd_ff;
  assign dmem_wr = dmem_wr_ff;
  assign dmem_wdata = dmem_wdata_ff;
  assign shd_w = shd_w_ff;
  assign shd_status = shd_status_ff;
  assign shd_bsr = shd_bsr_ff;
  assign shd_pclath = shd_pclath_ff;
  assign ctx_restore = ctx_restore_ff;
endmodule // pcs_core

//--- testbench/pcs_flash_model.sv
// Purpose: Behavioural program flash array facing the core
// Assumes: Combinational read of fourteen-bit words
// Notes:   Low byte is the inverse of the address, so a wrong fetch shows
module pcs_flash_model
(
  // Array address
  input wire logic [pcs_pkg::PC_W-1:0] pfm_addr,
  // Addressed word
  output logic [pcs_pkg::WORD_W-1:0] pfm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  // ==========
  // Word pattern differs in every low byte
  assign pfm_rdata = {pfm_addr[5:0], ~pfm_addr[7:0]};
endmodule // pcs_flash_model

//--- testbench/pcs_core_properties.sv
// Purpose: Port assertions for the counter and stack block
// Assumes: One clock domain, bound into pcs_core
// Notes:   Pointer bit 15 is tracked here to judge indirect writes
module pcs_core_chk
  import pcs_pkg::*;
#(
  parameter int PROG_WORDS = 8192
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Program flow
  input wire logic pc_inc,
  input wire logic pc_jump,
  input wire logic pc_call,
  input wire logic pc_ret,
  input wire logic pc_retint,
  input wire logic int_take,
  input wire logic [pcs_pkg::PC_W-1:0] pc_target,
  input wire logic stall,
  input wire logic ctx_restore,
  // Flash side
  input wire logic [pcs_pkg::PC_W-1:0] pfm_addr,
  input wire logic [pcs_pkg::WORD_W-1:0] pfm_rdata,
  input wire logic pfm_hef_hit,
  input wire logic [pcs_pkg::WORD_W-1:0] pfm_hef_lanes,
  // Indirect access
  input wire logic ptr_wr,
  input wire logic ptr_wsel,
  input wire logic ptr_whigh,
  input wire logic [7:0] ptr_wdata,
  input wire logic ind_rd,
  input wire logic ind_wr,
  input wire logic ind_sel,
  input wire logic ind_valid,
  input wire logic [7:0] ind_rdata,
  input wire logic dmem_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Helpers
  localparam logic [14:0] WRAP = 15'(PROG_WORDS - 1); // Implemented address mask
  logic [1:0] prog_ptr_ff; // Program flag of each pointer
  wire logic others = pc_jump || pc_call || pc_ret || pc_retint || int_take;
  wire logic lone_call = pc_call && !(pc_ret || pc_retint || int_take);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Follow high-byte writes; the block's own flops are not visible here
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      prog_ptr_ff <= 2'h0;
    else if (ptr_wr && ptr_whigh)
      prog_ptr_ff[ptr_wsel] <= ptr_wdata[7];
  end
  // ==========
  // Assertions
  chk_reset_start: assert property ($past(rst) |-> pfm_addr == RESET_VEC)
    else $error("no start after reset");
  chk_int_vector: assert property (int_take && !stall |=> pfm_addr == INT_VEC)
    else $error("vector missed");
  chk_call_target: assert property (
    lone_call && !stall |=> pfm_addr == ($past(pc_target) & WRAP))
    else $error("call target");
  chk_inc_wrap: assert property (
    pc_inc && !others && !stall && !$past(stall)
    |=> pfm_addr == (($past(pfm_addr) + 15'h1) & WRAP))
    else $error("increment");
  chk_hef_lanes: assert property (
    pfm_hef_hit == (pfm_addr >= 15'(PROG_WORDS - 128))
    && pfm_hef_lanes == (pfm_hef_hit ? HEF_LANES : 14'h0))
    else $error("endurance decode");
  chk_prog_fetch: assert property (
    ind_rd && stall |-> ##2 ind_valid && ind_rdata == 8'($past(pfm_rdata)))
    else $error("program read");
  chk_prog_write: assert property (ind_wr && prog_ptr_ff[ind_sel] |=> !dmem_wr)
    else $error("program write");
  chk_restore_pulse: assert property (
    pc_retint && !int_take && !stall |-> ##[1:2] ctx_restore)
    else $error("no restore");
  // Main scenarios reached
  cov_interrupt: cover property (int_take);
  cov_prog_read: cover property (ind_rd && stall);
  cov_hef: cover property (pfm_hef_hit);
endmodule // pcs_core_chk

bind pcs_core pcs_core_chk #(.PROG_WORDS(PROG_WORDS)) u_chk (.*);

//--- testbench/pcs_core_tb.sv
// Purpose: Self-checking bench for the counter and stack block
// Assumes: 8K-word array, 16-entry stack
// Notes:   Strobes leave a gap, so no signal is set twice at one edge
module pcs_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  // ==========
  // Signals
  localparam logic [5:0] INC = 6'h01, JMP = 6'h02, CALL = 6'h04;
  localparam logic [5:0] RET = 6'h08, RETI = 6'h10, INTR = 6'h20;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [5:0] fl = 6'h00; // Strobes: int, retint, ret, call, jump, inc
  logic [14:0] pc_target = 15'h0000;
  logic [7:0] ctx_w = 8'h00, ctx_status = 8'h00, ctx_bsr = 8'h00, ctx_pclath = 8'h00;
  logic ptr_wr = 1'h0, ptr_wsel = 1'h0, ptr_whigh = 1'h0;
  logic [7:0] ptr_wdata = 8'h00, ind_wdata = 8'h5a, reg_wdata = 8'h00;
  logic ind_rd = 1'h0, ind_wr = 1'h0, ind_sel = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic stall, pfm_hef_hit, ctx_restore, ind_valid, dmem_rd, dmem_wr, irq, stack_reset_req;
  logic [14:0] pfm_addr;
  logic [13:0] pfm_rdata, pfm_hef_lanes;
  logic [7:0] shd_w, shd_status, shd_bsr, shd_pclath, ind_rdata, dmem_wdata, reg_rdata;
  logic [11:0] dmem_addr;
  logic [7:0] rv; // Last register read
  logic st; // Stall in the request cycle
  int err_count = 0, n_checks = 0, cyc = 0;
  always #2 clk_sys = ~clk_sys;
  // Flow strobes come from one vector; every other port meets its namesake
  pcs_core #(.PROG_WORDS(8192), .STACK_DEPTH(16)) uut (.pc_inc(fl[0]), .pc_jump(fl[1]),
    .pc_call(fl[2]), .pc_ret(fl[3]), .pc_retint(fl[4]), .int_take(fl[5]), .*);
  pcs_flash_model flash (.*);
  // ==========
  // Bus and compare tasks
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic do_reset();
    rst <= 1'h1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
  endtask
  // One flow strobe, then settle past the taking edge
  task automatic flow(input logic [5:0] op, input logic [14:0] tgt);
    @(posedge clk_sys);
    fl <= op;
    pc_target <= tgt;
    @(posedge clk_sys);
    fl <= 6'h00;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 rv = reg_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    #1;
  endtask
  // Pointer bytes go in back to back, low byte first
  task automatic ptr(input logic sel, input logic [15:0] v);
    @(posedge clk_sys);
    ptr_wr <= 1'h1;
    ptr_wsel <= sel;
    ptr_whigh <= 1'h0;
    ptr_wdata <= v[7:0];
    @(posedge clk_sys);
    ptr_whigh <= 1'h1;
    ptr_wdata <= v[15:8];
    @(posedge clk_sys);
    ptr_wr <= 1'h0;
  endtask
  task automatic ind(input logic w, input logic sel);
    @(posedge clk_sys);
    ind_rd <= !w;
    ind_wr <= w;
    ind_sel <= sel;
    #1 st = stall;
    @(posedge clk_sys);
    ind_rd <= 1'h0;
    ind_wr <= 1'h0;
    #1;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset();
    flow(CALL, 15'h0040);
    do_reset();
    check("pc", pfm_addr, 16'h0000);
    rd(REG_DEPTH);
    check("depth", rv, 16'h0000);
    rd(REG_PWR);
    check("flags", {rv, 7'h00, irq}, 16'h0000);
  endtask
  task automatic t_stack();
    for (int i = 0; i < 16; i++)
    begin
      flow(CALL, 15'h0100 + 15'(i));
      check("call pc", pfm_addr, 16'h0100 + 16'(i));
    end
    rd(REG_DEPTH);
    check("full depth", rv, 16'h0010);
    flow(CALL, 15'h0200);
    rd(REG_PWR);
    check("overflow", {rv, 7'h00, irq}, 16'h0100);
    wr(REG_MASK, 8'h03);
    check("irq", irq, 16'h0001);
    wr(REG_PWR, 8'h01);
    check("irq clear", irq, 16'h0000);
    for (int i = 15; i >= 0; i--)
    begin
      flow(RET, 15'h0000);
      check("ret pc", pfm_addr, (i == 0) ? 16'h0001 : 16'h0100 + 16'(i));
    end
    flow(RET, 15'h0000);
    check("empty pop pc", pfm_addr, 16'h0000);
    check("no reset request", stack_reset_req, 16'h0000);
    rd(REG_PWR);
    check("underflow", {rv, 7'h00, irq}, 16'h0201);
    wr(REG_PWR, 8'h02);
    wr(REG_MASK, 8'h00);
    rd(4'hf);
    check("unmapped", rv, 16'h0000);
  endtask
  task automatic t_stkreset();
    wr(REG_CTRL, 8'h01);
    flow(RET, 15'h0000);
    check("reset request", stack_reset_req, 16'h0001);
    wr(REG_CTRL, 8'h00);
    wr(REG_PWR, 8'h03);
  endtask
  task automatic t_wrap();
    flow(JMP, 15'h7fff);
    check("wrap pc", pfm_addr, 16'h1fff);
    check("hef top", {pfm_hef_hit, 1'h0, pfm_hef_lanes}, 16'h80ff);
    rd(REG_PCH);
    check("pc high", rv, 16'h007f);
    flow(INC, 15'h0000);
    check("inc wrap", pfm_addr, 16'h0000);
    flow(JMP, 15'h1f80);
    check("hef edge", pfm_hef_hit, 16'h0001);
    flow(JMP, 15'h1f7f);
    check("below hef", {pfm_hef_hit, pfm_hef_lanes}, 16'h0000);
  endtask
  task automatic t_interrupt();
    flow(JMP, 15'h0123);
    @(posedge clk_sys);
    {ctx_w, ctx_status, ctx_bsr, ctx_pclath} <= 32'h11221f44;
    flow(INTR, 15'h0000);
    check("int pc", pfm_addr, 16'h0004);
    ctx_w <= 8'h99;
    check("shadow a", {shd_w, shd_status}, 16'h1122);
    check("shadow b", {shd_bsr, shd_pclath}, 16'h1f44);
    flow(RETI, 15'h0000);
    check("resume pc", pfm_addr, 16'h0123);
    check("restore", {ctx_restore, shd_w}, 16'h0111);
  endtask
  task automatic pread(input logic [15:0] p, input logic [15:0] a);
    ptr(1'h0, p);
    ind(1'h0, 1'h0);
    check("stall", st, 16'h0001);
    check("fetch addr", pfm_addr, a);
    @(posedge clk_sys);
    #1;
    check("ind data", {ind_valid, ind_rdata}, {8'h01, ~a[7:0]});
  endtask
  task automatic dacc(input logic w, input logic [15:0] p, input logic [15:0] a);
    ptr(1'h1, p);
    ind(w, 1'h1);
    check("data strobe", w ? dmem_wr : dmem_rd, 16'h0001);
    check("data addr", dmem_addr, a);
  endtask
  task automatic t_indirect();
    pread(16'h8010, 16'h0010);
    pread(16'hff85, 16'h1f85);
    ind(1'h1, 1'h0);
    check("prog write", {dmem_wr, dmem_rd}, 16'h0000);
    dacc(1'h0, 16'h204f, 16'h006f);
    dacc(1'h0, 16'h2050, 16'h00a0);
    dacc(1'h1, 16'h0123, 16'h0123);
    check("write data", dmem_wdata, 16'h005a);
  endtask
  // ==========
  // Sequence and hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      end_of_test();
    end
  end
  initial
  begin
    do_reset();
    t_reset();
    t_stack();
    t_stkreset();
    t_wrap();
    t_interrupt();
    t_indirect();
    end_of_test();
  end
endmodule // pcs_core_tb
